// ===== rtl/cl_sync_monitor.sv
// Link timing monitor: frame and line length checks with an AHB-Lite register slave.
//
// Functional notes
// - Keep a writable 24-bit expected lines per frame, used for every frame comparison.
// - A frame line count differing from expected sets the frame error and halts frame checking.
// - Any frame or line error sets the sync-lost status; interrupt only when masked in.
// - Frame line counts are compared only while the frame enable is one.
// - Frame learn bit counts the next frame, stores it as expected, then clears itself.
// - Keep a writable 24-bit expected clocks per line shared by all three inputs.
// - Base line length mismatch sets base error and halts base checking until re-enabled.
// - Medium line length mismatch sets medium error and halts medium checking until re-enabled.
// - Full line length mismatch sets full error and halts full checking until re-enabled.
// - Base, medium and full checks have own enables at bits 28, 29 and 30.
// - Line learn bit counts clocks of the next line, stores it, then clears itself.
// - Measured lines of each frame are shown, frozen at the offending frame after a mismatch.
// - Measured clocks per line are shown per input, frozen at the offending line.
//
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
module cl_sync_monitor (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic HSEL,
   input wire logic [cl_monitor_pkg::ADDR_W-1:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [cl_monitor_pkg::DATA_W-1:0] HWDATA,
   input wire logic HREADY,
   output logic [cl_monitor_pkg::DATA_W-1:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic CL_CLK,
   input wire logic CL_FVAL,
   input wire logic CL_LVAL_BASE,
   input wire logic CL_LVAL_MEDIUM,
   input wire logic CL_LVAL_FULL,
   output logic SYNC_LOST_HOST_IRQ
);
   import cl_monitor_pkg::*;

   logic [1:0] rst_pipe;
   logic rst_n;
   link_s link_meta, link_sync;
   logic clk_q, fval_q, link_edge, frame_start, frame_end;
   logic [CH_N-1:0] lval_q, line_start, line_end;
   bus_req_s dp;
   logic rd_done, wr_en;
   logic [DATA_W-1:0] rd_mux;
   count_t frame_cnt, exp_lines, exp_clocks, frame_meas;
   logic frame_err, frame_on, frame_learn, frame_learning, frame_live, frame_mismatch, frame_learn_done;
   logic line_learn, line_learning, line_learn_done;
   logic [CH_N-1:0] line_err, line_on, line_mismatch;
   logic [CH_N-1:0][CNT_W-1:0] line_cnt, line_meas;
   logic irq_status, irq_mask, any_mismatch;

   // The reset is released through two flops so that every register leaves reset on the same edge.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // Clock and valids share one two-flop chain so that they keep their relative timing.
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         link_meta <= '0;
         link_sync <= '0;
      end else begin
         link_meta <= '{clk: CL_CLK, fval: CL_FVAL, lval: {CL_LVAL_FULL, CL_LVAL_MEDIUM, CL_LVAL_BASE}};
         link_sync <= link_meta;
      end
   end

   // The valids are taken only on a rising link clock edge, as the camera launches them.
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         clk_q <= 1'b0;
         fval_q <= 1'b0;
         lval_q <= '0;
      end else begin
         clk_q <= link_sync.clk;
         if (link_edge) begin
            fval_q <= link_sync.fval;
            lval_q <= link_sync.lval;
         end
      end
   end

   assign link_edge = link_sync.clk & ~clk_q;
   assign frame_start = link_edge & link_sync.fval & ~fval_q;
   assign frame_end = link_edge & ~link_sync.fval & fval_q;

   // Lines of a frame are counted as rising base line valids while frame valid is high.
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         frame_cnt <= RST_MEASURED;
      end else if (frame_start) begin
         frame_cnt <= {{(CNT_W-1){1'b0}}, line_start[CH_BASE]};
      end else if (link_edge && link_sync.fval && line_start[CH_BASE]) begin
         frame_cnt <= frame_cnt + count_t'(1);
      end
   end

   // A frame is judged only if checking was already on at its start, so a late enable cannot misfire.
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         frame_live <= 1'b0;
         frame_learning <= 1'b0;
      end else if (frame_start) begin
         frame_live <= frame_on & ~frame_err;
         frame_learning <= frame_learn;
      end else if (frame_end) begin
         frame_live <= 1'b0;
         frame_learning <= 1'b0;
      end
   end

   assign frame_mismatch = frame_end & frame_live & frame_on & ~frame_err & ~frame_learning
                           & (frame_cnt != exp_lines);
   assign frame_learn_done = frame_end & frame_learning;

   // Bus: writes complete with no wait; reads take one wait state so that read data come from a flop.
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         dp <= '0;
      end else if (HREADY) begin
         dp <= '{sel: HSEL & HTRANS[1], wr: HWRITE, addr: HADDR};
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         rd_done <= 1'b0;
         HRDATA <= '0;
      end else begin
         rd_done <= dp.sel & ~dp.wr & ~rd_done;
         if (dp.sel && !dp.wr && !rd_done) begin
            HRDATA <= rd_mux;
         end
      end
   end

   assign HREADYOUT = ~(dp.sel & ~dp.wr & ~rd_done);
   assign HRESP = 1'b0;
   assign wr_en = dp.sel & dp.wr;

   always_comb begin
      rd_mux = '0;
      unique case (dp.addr)
         OFS_FRAME_CHECK: begin
            rd_mux[CNT_W-1:0] = exp_lines;
            rd_mux[BIT_FRAME_ERR] = frame_err;
            rd_mux[BIT_FRAME_ON] = frame_on;
            rd_mux[BIT_LEARN] = frame_learn;
         end
         OFS_LINE_CHECK: begin
            rd_mux[CNT_W-1:0] = exp_clocks;
            rd_mux[BIT_LINE_ERR0 +: CH_N] = line_err;
            rd_mux[BIT_LINE_ON0 +: CH_N] = line_on;
            rd_mux[BIT_LEARN] = line_learn;
         end
         OFS_FRAME_MEAS: rd_mux[CNT_W-1:0] = frame_meas;
         OFS_BASE_MEAS: rd_mux[CNT_W-1:0] = line_meas[0];
         OFS_MEDIUM_MEAS: rd_mux[CNT_W-1:0] = line_meas[1];
         OFS_FULL_MEAS: rd_mux[CNT_W-1:0] = line_meas[2];
         OFS_IRQ_STATUS: rd_mux[BIT_SYNC_LOST] = irq_status;
         OFS_IRQ_MASK: rd_mux[BIT_SYNC_LOST] = irq_mask;
         default: rd_mux = '0;
      endcase
   end

   // Frame check register. A learned value wins over a write landing in the same cycle.
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         exp_lines <= RST_EXPECTED;
      end else if (frame_learn_done) begin
         exp_lines <= frame_cnt;
      end else if (wr_en && dp.addr == OFS_FRAME_CHECK) begin
         exp_lines <= HWDATA[CNT_W-1:0];
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         frame_err <= 1'b0;
      end else if (frame_mismatch) begin
         frame_err <= 1'b1;
      end else if (wr_en && dp.addr == OFS_FRAME_CHECK && !HWDATA[BIT_FRAME_ERR]) begin
         frame_err <= 1'b0;
      end
   end

   // The enable drops on a mismatch, so checking resumes only when software writes it again.
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         frame_on <= RST_CHECK_ON;
      end else if (frame_mismatch) begin
         frame_on <= 1'b0;
      end else if (wr_en && dp.addr == OFS_FRAME_CHECK) begin
         frame_on <= HWDATA[BIT_FRAME_ON];
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         frame_learn <= 1'b0;
      end else if (wr_en && dp.addr == OFS_FRAME_CHECK && HWDATA[BIT_LEARN]) begin
         frame_learn <= 1'b1;
      end else if (frame_learn_done) begin
         frame_learn <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         frame_meas <= RST_MEASURED;
      end else if (frame_end && !frame_err) begin
         frame_meas <= frame_cnt;
      end
   end

   // Line check register fields shared by the three inputs.
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         exp_clocks <= RST_EXPECTED;
      end else if (line_learn_done) begin
         exp_clocks <= line_cnt[CH_BASE];
      end else if (wr_en && dp.addr == OFS_LINE_CHECK) begin
         exp_clocks <= HWDATA[CNT_W-1:0];
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         line_learn <= 1'b0;
      end else if (wr_en && dp.addr == OFS_LINE_CHECK && HWDATA[BIT_LEARN]) begin
         line_learn <= 1'b1;
      end else if (line_learn_done) begin
         line_learn <= 1'b0;
      end
   end

   // Learning measures the next whole base line; no input is judged during that line.
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         line_learning <= 1'b0;
      end else if (line_start[CH_BASE]) begin
         line_learning <= line_learn;
      end else if (line_end[CH_BASE]) begin
         line_learning <= 1'b0;
      end
   end
   assign line_learn_done = line_end[CH_BASE] & line_learning;

   for (genvar i = 0; i < CH_N; i++) begin : g_line
      count_t cnt;
      count_t meas;
      logic live;
      logic err;
      logic on;

      assign line_start[i] = link_edge & link_sync.lval[i] & ~lval_q[i];
      assign line_end[i] = link_edge & ~link_sync.lval[i] & lval_q[i];
      assign line_mismatch[i] = line_end[i] & live & on & ~err & ~line_learning & (cnt != exp_clocks);
      assign line_cnt[i] = cnt;
      assign line_meas[i] = meas;
      assign line_err[i] = err;
      assign line_on[i] = on;

      always_ff @(posedge CLK_SYS or negedge rst_n) begin
         if (!rst_n) begin
            cnt <= RST_MEASURED;
         end else if (line_start[i]) begin
            cnt <= count_t'(1);
         end else if (link_edge && link_sync.lval[i]) begin
            cnt <= cnt + count_t'(1);
         end
      end

      always_ff @(posedge CLK_SYS or negedge rst_n) begin
         if (!rst_n) begin
            live <= 1'b0;
         end else if (line_start[i]) begin
            live <= on & ~err;
         end else if (line_end[i]) begin
            live <= 1'b0;
         end
      end

      always_ff @(posedge CLK_SYS or negedge rst_n) begin
         if (!rst_n) begin
            err <= 1'b0;
         end else if (line_mismatch[i]) begin
            err <= 1'b1;
         end else if (wr_en && dp.addr == OFS_LINE_CHECK && !HWDATA[BIT_LINE_ERR0 + i]) begin
            err <= 1'b0;
         end
      end

      always_ff @(posedge CLK_SYS or negedge rst_n) begin
         if (!rst_n) begin
            on <= RST_CHECK_ON;
         end else if (line_mismatch[i]) begin
            on <= 1'b0;
         end else if (wr_en && dp.addr == OFS_LINE_CHECK) begin
            on <= HWDATA[BIT_LINE_ON0 + i];
         end
      end

      always_ff @(posedge CLK_SYS or negedge rst_n) begin
         if (!rst_n) begin
            meas <= RST_MEASURED;
         end else if (line_end[i] && !err) begin
            meas <= cnt;
         end
      end
   end

   // Interrupt: sticky status cleared by writing one, a new event in the same cycle wins.
   assign any_mismatch = frame_mismatch | (|line_mismatch);

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= 1'b0;
      end else if (any_mismatch) begin
         irq_status <= 1'b1;
      end else if (wr_en && dp.addr == OFS_IRQ_STATUS && HWDATA[BIT_SYNC_LOST]) begin
         irq_status <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask <= RST_MASK;
      end else if (wr_en && dp.addr == OFS_IRQ_MASK) begin
         irq_mask <= HWDATA[BIT_SYNC_LOST];
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         SYNC_LOST_HOST_IRQ <= 1'b0;
      end else begin
         SYNC_LOST_HOST_IRQ <= irq_status & irq_mask;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!rst_n);

   AST_FRAME_ERR_SET: assert property (frame_mismatch |=> frame_err && !frame_on)
      else $error("frame mismatch did not set the error and halt checking");
   AST_FRAME_CHECK_OFF: assert property (!frame_on && !frame_err |=> !frame_err)
      else $error("frame error set while frame checking was off");
   AST_FRAME_LEARN: assert property (frame_learn_done |=> exp_lines == $past(frame_cnt) && !frame_learn)
      else $error("frame learn did not store the count or clear itself");
   AST_FRAME_EXP_WRITE: assert property (wr_en && dp.addr == OFS_FRAME_CHECK && !frame_learn_done
      |=> exp_lines == $past(HWDATA[CNT_W-1:0]))
      else $error("expected lines did not take the written value");
   AST_FRAME_MEAS: assert property (frame_end && !frame_err |=> frame_meas == $past(frame_cnt))
      else $error("measured lines not refreshed at frame end");
   AST_FRAME_MEAS_HOLD: assert property (frame_err && $past(frame_err) |-> $stable(frame_meas))
      else $error("measured lines changed after a mismatch");
   AST_LINE_ERR_SET: assert property (|line_mismatch |=> (line_err & $past(line_mismatch)) == $past(line_mismatch)
      && (line_on & $past(line_mismatch)) == '0)
      else $error("line mismatch did not set its error and halt its check");
   AST_LINE_CHECK_OFF: assert property ((line_err & ~$past(line_on) & ~$past(line_err)) == '0)
      else $error("line mismatch raised on a disabled input");
   AST_LINE_LEARN: assert property (line_learn_done |=> exp_clocks == $past(line_cnt[CH_BASE]) && !line_learn)
      else $error("line learn did not store the count or clear itself");
   AST_LINE_EXP_WRITE: assert property (wr_en && dp.addr == OFS_LINE_CHECK && !line_learn_done
      |=> exp_clocks == $past(HWDATA[CNT_W-1:0]))
      else $error("expected clocks did not take the written value");
   AST_LINE_MEAS: assert property (line_end[0] && !line_err[0] |=> line_meas[0] == $past(line_cnt[0]))
      else $error("measured base clocks not refreshed at line end");
   AST_IRQ_STATUS: assert property (any_mismatch |=> irq_status ##1 SYNC_LOST_HOST_IRQ == $past(irq_mask))
      else $error("sync-lost status or interrupt not raised after a mismatch");
   AST_IRQ_MASKED: assert property (!irq_mask |=> !SYNC_LOST_HOST_IRQ)
      else $error("interrupt raised while masked");
   AST_LINK_EDGE: assert property (!$past(link_edge) |-> $stable(frame_meas) && $stable(line_meas))
      else $error("measured count changed without a link clock edge");
endmodule

// ===== shared/cl_monitor_pkg.sv
// Register map, field positions, reset values and carrier types of the link timing monitor.
package cl_monitor_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CNT_W = 24;
   localparam int unsigned CH_N = 3;
   localparam int unsigned CH_BASE = 0;

   localparam logic [ADDR_W-1:0] OFS_FRAME_CHECK = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_LINE_CHECK = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_FRAME_MEAS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_BASE_MEAS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_MEDIUM_MEAS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_FULL_MEAS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1C;

   localparam int unsigned BIT_FRAME_ERR = 24;
   localparam int unsigned BIT_FRAME_ON = 28;
   localparam int unsigned BIT_LEARN = 31;
   localparam int unsigned BIT_LINE_ERR0 = 24;
   localparam int unsigned BIT_LINE_ON0 = 28;
   localparam int unsigned BIT_SYNC_LOST = 0;

   localparam logic [CNT_W-1:0] RST_EXPECTED = 24'h000000;
   localparam logic [CNT_W-1:0] RST_MEASURED = 24'h000000;
   localparam logic RST_CHECK_ON = 1'b0;
   localparam logic RST_MASK = 1'b0;

   typedef logic [CNT_W-1:0] count_t;

   // Link pins as sampled together through one synchroniser.
   typedef struct packed {
      logic clk;
      logic fval;
      logic [CH_N-1:0] lval;
   } link_s;

   // Captured address phase of the register bus.
   typedef struct packed {
      logic sel;
      logic wr;
      logic [ADDR_W-1:0] addr;
   } bus_req_s;
endpackage

// ===== tb/cl_camera_model.sv
// Camera model that drives the link clock, frame valid and the three line valids.
`timescale 1ns/1ns
module cl_camera_model (
   output logic cl_clk,
   output logic fval,
   output logic lval_base,
   output logic lval_medium,
   output logic lval_full
);
   initial begin
      cl_clk = 1'b0;
      fval = 1'b0;
      lval_base = 1'b0;
      lval_medium = 1'b0;
      lval_full = 1'b0;
   end

   // Levels change only while the clock is low, so each rising edge sees settled data.
   task automatic tick();
      #31 cl_clk = 1'b1;
      #62 cl_clk = 1'b0;
      #32;
   endtask

   // The clock runs only inside a frame plus two closing edges, then stands still low.
   // Line valids rise together with frame valid so the first line starts on the frame edge.
   task automatic send_frame(input int lines, input int len_b, input int len_m, input int len_f);
      int longest;
      longest = (len_b > len_m) ? len_b : len_m;
      if (len_f > longest) begin
         longest = len_f;
      end
      fval = 1'b1;
      for (int l = 0; l < lines; l++) begin
         for (int c = 0; c < longest; c++) begin
            lval_base = (c < len_b);
            lval_medium = (c < len_m);
            lval_full = (c < len_f);
            tick();
         end
         lval_base = 1'b0;
         lval_medium = 1'b0;
         lval_full = 1'b0;
         tick();
         tick();
      end
      fval = 1'b0;
      tick();
      tick();
   endtask
endmodule

// ===== tb/cl_sync_monitor_tb.sv
// Self-checking bench for the link timing monitor, its register bus and its interrupt.
`timescale 1ns/1ns
module cl_sync_monitor_tb;
   import cl_monitor_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [ADDR_W-1:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [DATA_W-1:0] hwdata = 32'h00000000;
   logic [DATA_W-1:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic cl_clk;
   logic cl_fval;
   logic lval_b;
   logic lval_m;
   logic lval_f;
   logic irq;
   int mismatches = 0;
   int tests_run = 0;

   always #5 clk_sys = ~clk_sys;

   cl_sync_monitor i_cl_sync_monitor (
      .CLK_SYS(clk_sys),
      .RST_N(rst_n),
      .HSEL(hsel),
      .HADDR(haddr),
      .HTRANS(htrans),
      .HWRITE(hwrite),
      .HSIZE(hsize),
      .HWDATA(hwdata),
      .HREADY(hreadyout),
      .HRDATA(hrdata),
      .HREADYOUT(hreadyout),
      .HRESP(hresp),
      .CL_CLK(cl_clk),
      .CL_FVAL(cl_fval),
      .CL_LVAL_BASE(lval_b),
      .CL_LVAL_MEDIUM(lval_m),
      .CL_LVAL_FULL(lval_f),
      .SYNC_LOST_HOST_IRQ(irq)
   );

   cl_camera_model i_cl_camera_model (
      .cl_clk(cl_clk),
      .fval(cl_fval),
      .lval_base(lval_b),
      .lval_medium(lval_m),
      .lval_full(lval_f)
   );

   task automatic end_of_test();
      $display("Counts: %0d compared, %0d mismatched", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check32(input logic [31:0] got, input logic [31:0] exp, input logic [ADDR_W-1:0] a);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t register %h read %h expected %h", $time, a, got, exp);
      end
   endtask

   task automatic check1(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t output bit %b expected %b", $time, got, exp);
      end
   endtask

   // A slave that never answers would hang the bus, so every wait has a bound.
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         mismatches++;
         $display("[FAIL] %0t bus wait ran out", $time);
         end_of_test();
      end
   endtask

   task automatic ahb_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= 1'b1;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
   endtask

   task automatic expect_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= 1'b0;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      wait_ready();
      check32(hrdata, exp, a);
      check1(hresp, 1'b0);
   endtask

   task automatic run_frame(input int lines, input int lb, input int lm, input int lf);
      i_cl_camera_model.send_frame(lines, lb, lm, lf);
      repeat (8) @(posedge clk_sys);
   endtask

   task automatic t_reset_map();
      for (int a = 0; a <= 32; a += 4) begin
         expect_reg(8'(a), 32'h00000000);
      end
      ahb_write(OFS_FRAME_MEAS, 32'h00000055);
      expect_reg(OFS_FRAME_MEAS, 32'h00000000);
      check1(irq, 1'b0);
      $display("Test reset_map done");
   endtask

   task automatic t_expected_rw();
      ahb_write(OFS_FRAME_CHECK, 32'h0E123456);
      expect_reg(OFS_FRAME_CHECK, 32'h00123456);
      ahb_write(OFS_LINE_CHECK, 32'h08ABCDEF);
      expect_reg(OFS_LINE_CHECK, 32'h00ABCDEF);
      $display("Test expected_rw done");
   endtask

   task automatic t_frame_check();
      ahb_write(OFS_FRAME_CHECK, 32'h00000003);
      run_frame(2, 4, 4, 4);
      expect_reg(OFS_FRAME_CHECK, 32'h00000003);
      expect_reg(OFS_FRAME_MEAS, 32'h00000002);
      expect_reg(OFS_LINE_CHECK, 32'h00ABCDEF);
      ahb_write(OFS_FRAME_CHECK, 32'h10000003);
      run_frame(3, 4, 4, 4);
      expect_reg(OFS_FRAME_CHECK, 32'h10000003);
      expect_reg(OFS_FRAME_MEAS, 32'h00000003);
      run_frame(2, 4, 4, 4);
      expect_reg(OFS_FRAME_CHECK, 32'h01000003);
      expect_reg(OFS_IRQ_STATUS, 32'h00000001);
      check1(irq, 1'b0);
      run_frame(4, 4, 4, 4);
      expect_reg(OFS_FRAME_MEAS, 32'h00000002);
      ahb_write(OFS_IRQ_MASK, 32'h00000001);
      repeat (3) @(posedge clk_sys);
      check1(irq, 1'b1);
      ahb_write(OFS_IRQ_STATUS, 32'h00000001);
      repeat (3) @(posedge clk_sys);
      check1(irq, 1'b0);
      ahb_write(OFS_FRAME_CHECK, 32'h00000003);
      ahb_write(OFS_FRAME_CHECK, 32'h10000003);
      run_frame(3, 4, 4, 4);
      expect_reg(OFS_FRAME_CHECK, 32'h10000003);
      $display("Test frame_check done");
   endtask

   task automatic t_line_check();
      ahb_write(OFS_FRAME_CHECK, 32'h00000003);
      ahb_write(OFS_LINE_CHECK, 32'h70000004);
      run_frame(1, 4, 5, 3);
      expect_reg(OFS_LINE_CHECK, 32'h16000004);
      expect_reg(OFS_BASE_MEAS, 32'h00000004);
      expect_reg(OFS_MEDIUM_MEAS, 32'h00000005);
      expect_reg(OFS_FULL_MEAS, 32'h00000003);
      check1(irq, 1'b1);
      ahb_write(OFS_IRQ_STATUS, 32'h00000001);
      ahb_write(OFS_LINE_CHECK, 32'h10000004);
      ahb_write(OFS_LINE_CHECK, 32'h70000004);
      run_frame(1, 6, 4, 4);
      expect_reg(OFS_LINE_CHECK, 32'h61000004);
      expect_reg(OFS_BASE_MEAS, 32'h00000006);
      expect_reg(OFS_MEDIUM_MEAS, 32'h00000004);
      expect_reg(OFS_IRQ_STATUS, 32'h00000001);
      $display("Test line_check done");
   endtask

   task automatic t_learn();
      ahb_write(OFS_FRAME_CHECK, 32'h80000000);
      expect_reg(OFS_FRAME_CHECK, 32'h80000000);
      run_frame(5, 2, 2, 2);
      expect_reg(OFS_FRAME_CHECK, 32'h00000005);
      ahb_write(OFS_LINE_CHECK, 32'h80000000);
      run_frame(1, 7, 7, 7);
      expect_reg(OFS_LINE_CHECK, 32'h00000007);
      ahb_write(OFS_FRAME_CHECK, 32'h10000005);
      run_frame(5, 3, 3, 3);
      expect_reg(OFS_FRAME_CHECK, 32'h10000005);
      $display("Test learn done");
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_reset_map();
      t_expected_rw();
      t_frame_check();
      t_line_check();
      t_learn();
      end_of_test();
   end
endmodule
